/* reset_host_model.sv */
// far side: reset button, oscillator start, flash start and guard word
`timescale 1ns/100ps
`default_nettype none
module reset_host_model #(
   parameter int OSC_DELAY = 6  // cycles from button release to oscillator up
) (
   // clock and device state
   input  wire logic        clk,
   input  wire logic        chip_reset,
   // bench controls
   input  wire logic        pin_hold,
   input  wire logic [31:0] guard_value,
   // device pins
   output logic             reset_pin_n,
   output logic             osc_running,
   output logic             flash_init_done,
   output logic [31:0]      guard_word,
   output logic             guard_word_valid
);
   logic [7:0] cnt_r;  // cycles since button release
   // oscillator dies while the button is held, so a button boot waits on it
   always_ff @(posedge clk) begin
      if (pin_hold) cnt_r <= 8'h00;
      else if (cnt_r != 8'hff) cnt_r <= cnt_r + 8'h01;
   end
   assign reset_pin_n = !pin_hold;
   assign osc_running = cnt_r >= 8'(OSC_DELAY);
   assign flash_init_done = cnt_r >= 8'(OSC_DELAY + 3);
   // word only valid during reset; otherwise junk so a late sample shows
   assign guard_word_valid = chip_reset;
   assign guard_word = chip_reset ? guard_value : ~guard_value;
endmodule : reset_host_model
`default_nettype wire

/* sysctl_pkg.sv */
// constants for the system reset, droop, guard and mapping block
package sysctl_pkg;
   // register indices on the plain port
   localparam logic [3:0] ADDR_STATUS   = 4'h0;  // sticky events, write one clears
   localparam logic [3:0] ADDR_MASK     = 4'h1;  // interrupt mask
   localparam logic [3:0] ADDR_RAW      = 4'h2;  // raw droop and guard state
   localparam logic [3:0] ADDR_MAP      = 4'h3;  // vector mapping
   localparam logic [3:0] ADDR_RSRC     = 4'h4;  // reset source flags
   localparam logic [3:0] ADDR_WAKE_EDG = 4'h5;  // edge wake enables, low word
   localparam logic [3:0] ADDR_WAKE_EDH = 4'h6;  // edge wake enables, high bits
   localparam logic [3:0] ADDR_WAKE_LVL = 4'h7;  // level wake enables
   // status bit positions
   localparam int ST_DROOP = 0;
   localparam int ST_WAKE  = 1;
   localparam int ST_W     = 2;
   // reset source bit positions
   localparam int RS_PIN   = 0;
   localparam int RS_WDT   = 1;
   localparam int RS_POR   = 2;
   localparam int RS_DROOP = 3;
   // input counts
   localparam int N_EDGE  = 50;
   localparam int N_LEVEL = 4;
   // vector map encodings
   localparam logic [1:0] MAP_BOOT = 2'h0;
   localparam logic [1:0] MAP_SRAM = 2'h1;
   localparam logic [1:0] MAP_EXT  = 2'h2;
   // guard flash patterns (arbitrary values)
   localparam logic [31:0] GUARD_PAT_ONE   = 32'h1234_5678;
   localparam logic [31:0] GUARD_PAT_TWO   = 32'h8765_4321;
   localparam logic [31:0] GUARD_PAT_THREE = 32'h4321_8765;
   // wake-up timer: fixed clock count after oscillator runs
   localparam int WAKE_CYCLES = 16;
   localparam logic [4:0] WAKE_LAST = 5'(WAKE_CYCLES - 1);
   // guard levels
   typedef enum logic [1:0] {
      GUARD_NONE  = 2'b00,
      GUARD_ONE   = 2'b01,
      GUARD_TWO   = 2'b10,
      GUARD_THREE = 2'b11
   } guard_type;
   // reset sequencer states
   typedef enum logic [1:0] {
      SQ_HOLD  = 2'b00,
      SQ_COUNT = 2'b01,
      SQ_FLASH = 2'b10,
      SQ_RUN   = 2'b11
   } seq_type;
endpackage : sysctl_pkg

/* system_reset_and_protection.sv */
// system reset sequencer, droop monitor, code read guard, vector map, wake
//
// The address-and-strobe port and the address map are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module system_reset_and_protection (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        reset,
   // reset sources, asynchronous pins
   input  wire logic        reset_pin_n,
   input  wire logic        watchdog_timeout,
   input  wire logic        power_on_detect,
   input  wire logic        droop_upper_low,
   input  wire logic        droop_lower_low,
   // readiness
   input  wire logic        osc_running,
   input  wire logic        flash_init_done,
   // guard pattern read from flash
   input  wire logic [31:0] guard_word,
   input  wire logic        guard_word_valid,
   // external interrupt pins
   input  wire logic [49:0] ext_edge_in,
   input  wire logic [3:0]  ext_level_in,
   input  wire logic        power_down,
   // register port
   input  wire logic [3:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic [31:0]      reg_rdata,
   // reset and system outputs
   output logic             chip_reset,
   output logic             supply_droop_irq,
   output logic             irq,
   output logic             wake_request,
   output logic [1:0]       vector_map,
   output logic             debug_port_enable,
   output logic             prog_allowed,
   output logic             prog_limited,
   output logic             prog_erase_only,
   output logic             sector0_locked,
   output logic             override_pin_enable
);
   localparam int NS = 5 + sysctl_pkg::N_EDGE + sysctl_pkg::N_LEVEL + 2; // sync width

   // three-stage synchronisers for all pins but power_down and the guard word
   logic [NS-1:0] s1_r, s2_r, s3_r;
   logic [NS-1:0] pin_vec;
   // pin and watchdog synchronised with the rest so source flags never read a raw pin
   assign pin_vec = {osc_running, flash_init_done, ext_level_in, ext_edge_in,
                     droop_lower_low, droop_upper_low, power_on_detect,
                     watchdog_timeout, ~reset_pin_n};
   // stage one read only by stage two
   always_ff @(posedge clk) begin
      s1_r <= pin_vec;
      s2_r <= s1_r;
      s3_r <= s2_r;
   end

   // filtered levels: change counts once stages two and three agree
   logic [NS-1:0] flt_r, flt_nxt;
   always_comb begin
      for (int i = 0; i < NS; i++) begin
         flt_nxt[i] = (s2_r[i] == s3_r[i]) ? s3_r[i] : flt_r[i];
      end
   end
   always_ff @(posedge clk) begin
      if (reset) begin
         flt_r <= '0;
      end else begin
         flt_r <= flt_nxt;
      end
   end

   // named views of filtered inputs
   logic        f_pin, f_wdt, f_por, f_up, f_low, f_osc, f_flash;
   logic [49:0] f_edge;
   logic [3:0]  f_lvl;
   assign f_pin   = flt_r[0];
   assign f_wdt   = flt_r[1];
   assign f_por   = flt_r[2];
   assign f_up    = flt_r[3];
   assign f_low   = flt_r[4];
   assign f_edge  = flt_r[54:5];
   assign f_lvl   = flt_r[58:55];
   assign f_flash = flt_r[59];
   assign f_osc   = flt_r[60];

   // any source asserting chip reset
   logic any_src;
   assign any_src = f_pin | f_wdt | f_por | f_low;

   // reset sequencer
   sysctl_pkg::seq_type sq_r, sq_nxt;
   logic [4:0] cnt_r, cnt_nxt;
   logic       crst_r, crst_nxt;
   always_comb begin
      sq_nxt   = sq_r;
      cnt_nxt  = cnt_r;
      crst_nxt = 1'b1;
      if (any_src) begin
         sq_nxt  = sysctl_pkg::SQ_HOLD; // restart wake timer
         cnt_nxt = '0;
      end else begin
         unique case (sq_r)
            sysctl_pkg::SQ_HOLD: begin
               if (f_osc) begin
                  sq_nxt = sysctl_pkg::SQ_COUNT;
               end
            end
            sysctl_pkg::SQ_COUNT: begin
               if (!f_osc) begin
                  sq_nxt  = sysctl_pkg::SQ_HOLD;
                  cnt_nxt = '0;
               end else if (cnt_r == sysctl_pkg::WAKE_LAST) begin
                  sq_nxt = sysctl_pkg::SQ_FLASH;
               end else begin
                  cnt_nxt = cnt_r + 5'h01;
               end
            end
            sysctl_pkg::SQ_FLASH: begin
               if (f_flash) begin
                  sq_nxt = sysctl_pkg::SQ_RUN;
               end
            end
            sysctl_pkg::SQ_RUN: begin
               crst_nxt = 1'b0; // released on one clock edge
            end
         endcase
      end
   end
   // sequencer registers
   always_ff @(posedge clk) begin
      if (reset) begin
         sq_r   <= sysctl_pkg::SQ_HOLD;
         cnt_r  <= '0;
         crst_r <= 1'b1;
      end else begin
         sq_r   <= sq_nxt;
         cnt_r  <= cnt_nxt;
         crst_r <= crst_nxt;
      end
   end
   assign chip_reset = crst_r;

   // internal reset for the software registers below but the reset flags: they reach defaults under it
   logic rst_all;
   assign rst_all = reset | crst_r;

   // guard level captured from flash pattern while chip is held in reset
   sysctl_pkg::guard_type guard_r, guard_nxt;
   always_comb begin
      guard_nxt = guard_r;
      if (crst_r && guard_word_valid) begin
         unique case (guard_word)
            sysctl_pkg::GUARD_PAT_ONE:   guard_nxt = sysctl_pkg::GUARD_ONE;
            sysctl_pkg::GUARD_PAT_TWO:   guard_nxt = sysctl_pkg::GUARD_TWO;
            sysctl_pkg::GUARD_PAT_THREE: guard_nxt = sysctl_pkg::GUARD_THREE;
            default:                     guard_nxt = sysctl_pkg::GUARD_NONE;
         endcase
      end
   end
   // guard outputs; in-application programming has no gate here at all
   logic dbg_nxt, prg_nxt, lim_nxt, ers_nxt, s0_nxt, ovr_nxt;
   always_comb begin
      dbg_nxt = 1'b1;
      prg_nxt = 1'b1;
      lim_nxt = 1'b0;
      ers_nxt = 1'b0;
      s0_nxt  = 1'b0;
      ovr_nxt = 1'b1;
      unique case (guard_r)
         sysctl_pkg::GUARD_NONE: begin
            dbg_nxt = 1'b1;
         end
         sysctl_pkg::GUARD_ONE: begin
            dbg_nxt = 1'b0;
            lim_nxt = 1'b1;
            s0_nxt  = 1'b1;
         end
         sysctl_pkg::GUARD_TWO: begin
            dbg_nxt = 1'b0;
            ers_nxt = 1'b1;
         end
         sysctl_pkg::GUARD_THREE: begin
            dbg_nxt = 1'b0;
            prg_nxt = 1'b0;
            ovr_nxt = 1'b0;
         end
      endcase
   end
   // guard registers; debug closed from one edge after chip reset rises until one edge after it falls
   logic dbg_r, prg_r, lim_r, ers_r, s0_r, ovr_r;
   always_ff @(posedge clk) begin
      if (reset) begin
         guard_r <= sysctl_pkg::GUARD_NONE;
         dbg_r   <= 1'b0;
         prg_r   <= 1'b0;
         lim_r   <= 1'b0;
         ers_r   <= 1'b0;
         s0_r    <= 1'b0;
         ovr_r   <= 1'b0;
      end else begin
         guard_r <= guard_nxt;
         dbg_r   <= dbg_nxt & ~crst_r;
         prg_r   <= prg_nxt;
         lim_r   <= lim_nxt;
         ers_r   <= ers_nxt;
         s0_r    <= s0_nxt;
         ovr_r   <= ovr_nxt;
      end
   end
   assign debug_port_enable   = dbg_r;
   assign prog_allowed        = prg_r;
   assign prog_limited        = lim_r;
   assign prog_erase_only     = ers_r;
   assign sector0_locked      = s0_r;
   assign override_pin_enable = ovr_r;

   // edge detection and wake; wake only armed during power-down
   logic [49:0] edge_prev_r;
   logic [49:0] wake_edge_en_r, wake_edge_en_nxt;
   logic [3:0]  wake_lvl_en_r, wake_lvl_en_nxt;
   logic        wake_hit;
   assign wake_hit = power_down &
                     ((|(f_edge & ~edge_prev_r & wake_edge_en_r)) |
                      (|(f_lvl & wake_lvl_en_r)));

   // registers written by software
   logic [sysctl_pkg::ST_W-1:0] stat_r, stat_nxt, mask_r, mask_nxt;
   logic [1:0] map_r, map_nxt;
   logic [3:0] rsrc_r, rsrc_nxt;
   logic [sysctl_pkg::ST_W-1:0] ev;
   always_comb begin
      ev = '0;
      ev[sysctl_pkg::ST_DROOP] = f_up;
      ev[sysctl_pkg::ST_WAKE]  = wake_hit;
      mask_nxt         = mask_r;
      map_nxt          = map_r;
      wake_edge_en_nxt = wake_edge_en_r;
      wake_lvl_en_nxt  = wake_lvl_en_r;
      stat_nxt         = stat_r;
      rsrc_nxt         = rsrc_r;
      if (reg_wr) begin
         unique case (reg_addr)
            sysctl_pkg::ADDR_STATUS:   stat_nxt = stat_r & ~reg_wdata[sysctl_pkg::ST_W-1:0];
            sysctl_pkg::ADDR_MASK:     mask_nxt = reg_wdata[sysctl_pkg::ST_W-1:0];
            sysctl_pkg::ADDR_MAP:      map_nxt  = reg_wdata[1:0];
            sysctl_pkg::ADDR_RSRC:     rsrc_nxt = rsrc_r & ~reg_wdata[3:0];
            sysctl_pkg::ADDR_WAKE_EDG: wake_edge_en_nxt[31:0] = reg_wdata;
            sysctl_pkg::ADDR_WAKE_EDH: wake_edge_en_nxt[49:32] = reg_wdata[17:0];
            sysctl_pkg::ADDR_WAKE_LVL: wake_lvl_en_nxt = reg_wdata[3:0];
            default: ;
         endcase
      end
      stat_nxt = stat_nxt | ev; // set wins over clear
      if (f_pin) rsrc_nxt[sysctl_pkg::RS_PIN]   = 1'b1;
      if (f_wdt) rsrc_nxt[sysctl_pkg::RS_WDT]   = 1'b1;
      if (f_por) rsrc_nxt[sysctl_pkg::RS_POR]   = 1'b1;
      if (f_low) rsrc_nxt[sysctl_pkg::RS_DROOP] = 1'b1;
   end
   // software state: defaults while chip reset holds; reset flags survive it
   always_ff @(posedge clk) begin
      if (reset) begin
         rsrc_r <= 4'h0;
      end else begin
         rsrc_r <= rsrc_nxt;
      end
      if (rst_all) begin
         stat_r         <= '0;
         mask_r         <= '0;
         map_r          <= sysctl_pkg::MAP_BOOT;
         wake_edge_en_r <= '0;
         wake_lvl_en_r  <= '0;
         edge_prev_r    <= '0;
      end else begin
         stat_r         <= stat_nxt;
         mask_r         <= mask_nxt;
         map_r          <= map_nxt;
         wake_edge_en_r <= wake_edge_en_nxt;
         wake_lvl_en_r  <= wake_lvl_en_nxt;
         edge_prev_r    <= f_edge;
      end
   end

   // read mux and registered outputs
   logic [31:0] rd_nxt;
   always_comb begin
      rd_nxt = 32'h0000_0000;
      if (reg_rd) begin
         unique case (reg_addr)
            sysctl_pkg::ADDR_STATUS:   rd_nxt[sysctl_pkg::ST_W-1:0] = stat_r;
            sysctl_pkg::ADDR_MASK:     rd_nxt[sysctl_pkg::ST_W-1:0] = mask_r;
            sysctl_pkg::ADDR_RAW:      rd_nxt[4:0] = {guard_r, 1'b0, f_low, f_up};
            sysctl_pkg::ADDR_MAP:      rd_nxt[1:0] = map_r;
            sysctl_pkg::ADDR_RSRC:     rd_nxt[3:0] = rsrc_r;
            sysctl_pkg::ADDR_WAKE_EDG: rd_nxt = wake_edge_en_r[31:0];
            sysctl_pkg::ADDR_WAKE_EDH: rd_nxt[17:0] = wake_edge_en_r[49:32];
            sysctl_pkg::ADDR_WAKE_LVL: rd_nxt[3:0] = wake_lvl_en_r;
            default:                   rd_nxt = 32'h0000_0000;
         endcase
      end
   end
   logic [31:0] rdata_r;
   logic        droop_irq_r, irq_r, wake_r;
   always_ff @(posedge clk) begin
      if (reset) begin
         rdata_r     <= '0;
         droop_irq_r <= 1'b0;
         irq_r       <= 1'b0;
         wake_r      <= 1'b0;
      end else begin
         rdata_r     <= rd_nxt;
         droop_irq_r <= f_up & ~crst_r;
         irq_r       <= |(stat_r & mask_r) & ~crst_r;
         wake_r      <= wake_hit;
      end
   end
   assign reg_rdata        = rdata_r;
   assign supply_droop_irq = droop_irq_r;
   assign irq              = irq_r;
   assign wake_request     = wake_r;
   assign vector_map       = map_r;
endmodule : system_reset_and_protection
`default_nettype wire

/* system_reset_and_protection_sva.sv */
// checker for the reset, droop, guard and vector map outputs
`timescale 1ns/100ps
`default_nettype none
module system_reset_and_protection_sva (
   // clock and reset
   input wire logic        clk,
   input wire logic        reset,
   // sources and readiness
   input wire logic        reset_pin_n,
   input wire logic        watchdog_timeout,
   input wire logic        power_on_detect,
   input wire logic        droop_upper_low,
   input wire logic        droop_lower_low,
   input wire logic        osc_running,
   input wire logic        flash_init_done,
   // register read side
   input wire logic        reg_rd,
   input wire logic [31:0] reg_rdata,
   // outputs watched
   input wire logic        chip_reset,
   input wire logic        supply_droop_irq,
   input wire logic [1:0]  vector_map,
   input wire logic        debug_port_enable,
   input wire logic        prog_allowed,
   input wire logic        prog_limited,
   input wire logic        prog_erase_only,
   input wire logic        sector0_locked,
   input wire logic        override_pin_enable
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   logic [7:0] hi_r;    // cycles chip_reset has stood high
   logic [7:0] hi_nxt;
   logic       src;     // any source asking for reset
   assign src = !reset_pin_n || watchdog_timeout || power_on_detect || droop_lower_low;
   // saturating count, so a long hold never wraps back to a small value
   always_comb begin
      hi_nxt = (hi_r == 8'hff) ? hi_r : hi_r + 8'h01;
      if (!chip_reset) hi_nxt = 8'h00;
   end
   always_ff @(posedge clk) begin
      hi_r <= reset ? 8'h00 : hi_nxt;
   end
   a_src_holds_reset: assert property (src [*6] |-> chip_reset)
      else $error("reset source did not hold chip reset");
   a_release_ready: assert property ($fell(chip_reset) |-> !src && osc_running && flash_init_done)
      else $error("reset released while not ready");
   a_wake_count: assert property ($fell(chip_reset) |-> hi_r >= 8'(sysctl_pkg::WAKE_CYCLES))
      else $error("reset released before the wake count");
   a_reset_clears: assert property ($fell(reset) |-> chip_reset && reg_rdata == 32'h0000_0000 && !debug_port_enable)
      else $error("outputs not at reset values");
   a_boot_map: assert property ($fell(chip_reset) |-> vector_map == sysctl_pkg::MAP_BOOT)
      else $error("vectors not from boot block at release");
   a_map_legal: assert property (vector_map != 2'h3)
      else $error("illegal vector map");
   a_droop_request: assert property ((droop_upper_low && !chip_reset) [*6] |-> supply_droop_irq)
      else $error("droop request missing");
   a_droop_quiet: assert property (!droop_upper_low [*6] |-> !supply_droop_irq)
      else $error("droop request without droop");
   a_level_one: assert property (prog_limited |-> sector0_locked && prog_allowed && !debug_port_enable)
      else $error("level one outputs wrong");
   a_level_two: assert property (prog_erase_only |-> !prog_limited && prog_allowed && !debug_port_enable)
      else $error("level two outputs wrong");
   a_level_three: assert property (!chip_reset && !prog_allowed |-> !override_pin_enable && !debug_port_enable)
      else $error("level three left an entry open");
   a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0000_0000)
      else $error("read data outside its cycle");
   c_release: cover property ($fell(chip_reset));
   c_limited: cover property (prog_limited && !chip_reset);
   c_droop: cover property (supply_droop_irq && !chip_reset);
endmodule : system_reset_and_protection_sva
bind system_reset_and_protection system_reset_and_protection_sva chk (.*);
`default_nettype wire

/* test_system_reset_and_protection.sv */
// bench: boot per guard level, reset sources, droop irq, map, wake
`timescale 1ns/100ps
`default_nettype none
module test_system_reset_and_protection;
   logic clk = 0, reset = 1, pin_hold = 1, power_down = 0;
   logic watchdog_timeout = 0, power_on_detect = 0;
   logic droop_upper_low = 0, droop_lower_low = 0;
   logic [31:0] guard_value = 0, reg_wdata = 0, reg_rdata, rd_val, guard_word;
   logic [49:0] ext_edge_in = 0;
   logic [3:0]  ext_level_in = 0, reg_addr = 0;
   logic reg_wr = 0, reg_rd = 0, reset_pin_n, osc_running, flash_init_done;
   logic guard_word_valid, chip_reset, supply_droop_irq, irq, wake_request;
   logic [1:0] vector_map;
   logic debug_port_enable, prog_allowed, prog_limited, prog_erase_only;
   logic sector0_locked, override_pin_enable;
   int miscompares = 0, checked = 0;
   system_reset_and_protection dut (.*);
   reset_host_model partner (.*);
   initial forever #4 clk = ~clk;
   task automatic results();
      $display("counts: %0d checked, %0d miscompares", checked, miscompares);
      if (miscompares == 0 && checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : results
   task automatic chk(input logic ok, input string m);
      checked++;
      if (ok !== 1'b1) begin
         miscompares++;
         $display("unexpected at %0t: %s", $time, m);
      end
   endtask : chk
   // settle one step past the edge so outputs of that edge have landed
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : cyc
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [3:0] a, output logic [31:0] v);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 v = reg_rdata;
   endtask : rd
   task automatic wait_run(output int n);
      n = 0;
      while (chip_reset !== 1'b0) begin
         cyc(1);
         n++;
         if (n > 300) begin
            miscompares++;
            results();
         end
      end
   endtask : wait_run
   task automatic seen8(output logic s);
      s = 1'b0;
      repeat (8) begin
         cyc(1);
         s = s | wake_request;
      end
   endtask : seen8
   task automatic t_boot(input int l);
      int n;
      logic [31:0] pats [4] = '{32'h0000_0000, sysctl_pkg::GUARD_PAT_ONE,
         sysctl_pkg::GUARD_PAT_TWO, sysctl_pkg::GUARD_PAT_THREE};
      guard_value <= pats[l];
      pin_hold <= 1'b1;
      cyc(6);
      pin_hold <= 1'b0;
      wait_run(n);
      cyc(1);  // debug port opens one edge after release
      chk(n >= 19, "released too early");
      chk(vector_map === sysctl_pkg::MAP_BOOT, "vectors not boot");
      chk({debug_port_enable, prog_allowed, override_pin_enable, prog_limited, prog_erase_only}
         === {l == 0, l != 3, l != 3, l == 1, l == 2}, "guard outputs");
      chk(sector0_locked === (l == 1), "sector zero lock");
      rd(sysctl_pkg::ADDR_RAW, rd_val);
      chk(rd_val[4:3] === 2'(l), "guard level read");
      rd(sysctl_pkg::ADDR_MASK, rd_val);
      chk(rd_val === 32'h0000_0000, "mask not reset");
      rd(sysctl_pkg::ADDR_RSRC, rd_val);
      chk(rd_val[sysctl_pkg::RS_PIN] === 1'b1, "pin flag");
      wr(sysctl_pkg::ADDR_RSRC, 32'h0000_000f);
      $display("boot level %0d done", l);
   endtask : t_boot
   task automatic t_src(input int i);
      int n;
      {droop_lower_low, power_on_detect, watchdog_timeout} <= 3'(1 << (i - 1));
      cyc(8);
      chk(chip_reset === 1'b1, "source ignored");
      if (i == 3) begin  // power-on takes over as the droop fades
         power_on_detect <= 1'b1;
         cyc(2);
         droop_lower_low <= 1'b0;
         cyc(8);
         chk(chip_reset === 1'b1, "reset lost in hand-over");
      end
      {droop_lower_low, power_on_detect, watchdog_timeout} <= 3'b000;
      wait_run(n);
      rd(sysctl_pkg::ADDR_RSRC, rd_val);
      chk(rd_val[i] === 1'b1, "source flag");
      wr(sysctl_pkg::ADDR_RSRC, 32'h0000_000f);
      $display("source %0d done", i);
   endtask : t_src
   task automatic t_droop();
      droop_upper_low <= 1'b1;
      cyc(8);
      chk(supply_droop_irq === 1'b1, "no droop request");
      rd(sysctl_pkg::ADDR_RAW, rd_val);
      chk(rd_val[0] === 1'b1 && irq === 1'b0, "raw or mask");
      wr(sysctl_pkg::ADDR_MASK, 32'h0000_0001);
      cyc(2);
      chk(irq === 1'b1, "unmasked irq missing");
      droop_upper_low <= 1'b0;
      cyc(8);
      chk(supply_droop_irq === 1'b0, "request stuck");
      wr(sysctl_pkg::ADDR_STATUS, 32'h0000_0001);
      cyc(2);
      chk(irq === 1'b0, "irq not cleared");
      rd(4'hf, rd_val);
      chk(rd_val === 32'h0000_0000, "unmapped read");
      $display("droop done");
   endtask : t_droop
   task automatic t_map();
      logic [1:0] m [3] = '{sysctl_pkg::MAP_SRAM, sysctl_pkg::MAP_EXT, sysctl_pkg::MAP_BOOT};
      foreach (m[k]) begin
         wr(sysctl_pkg::ADDR_MAP, {30'h0000_0000, m[k]});
         rd(sysctl_pkg::ADDR_MAP, rd_val);
         chk(rd_val[1:0] === m[k] && vector_map === m[k], "vector map");
      end
      $display("map done");
   endtask : t_map
   task automatic t_wake();
      logic s;
      power_down <= 1'b1;
      ext_edge_in[0] <= 1'b1;  // not enabled, must stay asleep
      seen8(s);
      chk(s === 1'b0, "wake from disabled pin");
      wr(sysctl_pkg::ADDR_WAKE_EDH, 32'h0002_0000);
      ext_edge_in[49] <= 1'b1;
      seen8(s);
      chk(s === 1'b1, "edge wake missing");
      rd(sysctl_pkg::ADDR_STATUS, rd_val);
      chk(rd_val[sysctl_pkg::ST_WAKE] === 1'b1, "wake status");
      wr(sysctl_pkg::ADDR_WAKE_LVL, 32'h0000_0001);
      ext_level_in[0] <= 1'b1;
      seen8(s);
      chk(s === 1'b1, "level wake missing");
      $display("wake done");
   endtask : t_wake
   initial begin
      cyc(20);
      reset <= 1'b0;
      for (int l = 1; l < 5; l++) t_boot(l % 4);
      for (int i = 1; i < 4; i++) t_src(i);
      t_droop();
      t_map();
      t_wake();
      results();
   end
endmodule : test_system_reset_and_protection
`default_nettype wire
